// file: cise_pkg.sv
// constants, encodings and carrier types for the instruction-slice executor
// assumes one 50 MHz core clock and an active-low asynchronous reset
//
// Operation
// - the bit toggle op inverts the one bit picked by the 3-bit index in the addressed byte and keeps the rest.
// - with the access flag at 0 the access bank is used, with it at 1 the bank named by the bank select reg.
// - access flag 0 with the extended set enabled and a file address up to 5Fh uses indexed literal offset.
// - branch on overflow (upper byte E4h) branches only while the overflow flag is one.
// - branch on zero (upper byte E0h) branches only while the zero flag is one.
// - a taken branch loads the counter with the counter plus two plus twice the signed 8-bit offset.
// - a branch is one word; one cycle when not taken, two when taken, the second a no-operation cycle.
// - the call pushes the counter plus four onto the return stack, then loads its 20-bit literal into bits 20..1.
// - a call with its fast flag set copies working, status and bank select into the shadows, else leaves them.
// - the call is two words, the first (1110 prefix) with literal bits 7..0, the second (1111) with bits 19..8.
// - the call spends its first cycle decoding, reading, pushing and writing the counter, then one idle cycle.
// - the clear file op writes zero to the addressed register and sets the zero flag, in one cycle.
// - the clear watchdog op zeroes the watchdog counter and postscaler and sets both active-low reset flags.
// - bit toggle, both branches and the call leave every arithmetic flag as it was.
package cise_pkg;
    localparam int PC_W = 21;
    localparam int DM_AW = 12;
    localparam int DATA_W = 32;
    localparam int RA_W = 4;
    localparam real CLK_NS = 20.0;

    // instruction encodings
    localparam logic [3:0] OP_BTG_PFX = 4'h7;
    localparam logic [7:0] OP_BOV = 8'hE4;
    localparam logic [7:0] OP_BZ = 8'hE0;
    localparam logic [6:0] OP_CALL_PFX = 7'h76;
    localparam logic [3:0] OP_CALL2_PFX = 4'hF;
    localparam logic [6:0] OP_CLEAR_FILE_OP_PFX = 7'h35;
    localparam logic [15:0] OP_CLEAR_WATCHDOG_OP = 16'h0004;
    localparam logic [15:0] OP_NOP = 16'h0000;

    // addressing
    localparam logic [7:0] INDEXED_MAX = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

    // status flag positions
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;

    // register indices
    localparam logic [RA_W-1:0] REG_CTRL = 4'h0;
    localparam logic [RA_W-1:0] REG_STATUS = 4'h1;
    localparam logic [RA_W-1:0] REG_BANK = 4'h2;
    localparam logic [RA_W-1:0] REG_WORK = 4'h3;
    localparam logic [RA_W-1:0] REG_FSR2 = 4'h4;
    localparam logic [RA_W-1:0] REG_PC = 4'h5;
    localparam logic [RA_W-1:0] REG_TOS = 4'h6;
    localparam logic [RA_W-1:0] REG_SHADOW = 4'h7;
    localparam logic [RA_W-1:0] REG_WDT = 4'h8;

    // reset values
    localparam logic [PC_W-1:0] PC_RST = 21'h00_0000;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] IR_RST = 16'h0000;

    typedef enum logic [0:0] {
        ST_EXEC = 1'b0,
        ST_FLUSH = 1'b1
    } cise_state_type;

    typedef struct packed {
        logic [DM_AW-1:0] addr;
        logic [7:0] wdata;
        logic we;
    } cise_dm_req_type;
endpackage

// file: cise_exec.sv
// executes the toggle, branch, call, clear-file and clear-watchdog slice of an 8-bit core
// assumes program memory answers prog_addr combinationally on instr_word, and
// data memory answers dm_req.addr combinationally on dm_rdata, both on this clock
`timescale 1ns/1ps
module cise_exec #(
    parameter int WDT_W = 8,
    parameter int POST_W = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // program memory
    input wire logic [15:0] instr_word,
    output logic [cise_pkg::PC_W-1:0] prog_addr,
    // data memory
    input wire logic [7:0] dm_rdata,
    output cise_pkg::cise_dm_req_type dm_req,
    // return stack
    output logic stack_push,
    output logic [cise_pkg::PC_W-1:0] stack_tos,
    // watchdog
    output logic wdt_timeout,
    // register port
    input wire logic [cise_pkg::RA_W-1:0] reg_addr,
    input wire logic [cise_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [cise_pkg::DATA_W-1:0] reg_rdata
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] q;
        cise_pkg::cise_state_type st;
        logic [15:0] ir;
        logic [cise_pkg::PC_W-1:0] pc;
        logic [cise_pkg::PC_W-1:0] fetch;
        logic [7:0] status;
        logic to_n;
        logic pd_n;
        logic [3:0] bank;
        logic [7:0] work;
        logic [cise_pkg::DM_AW-1:0] fsr2;
        logic ext_en;
        logic [7:0] work_sh;
        logic [7:0] status_sh;
        logic [3:0] bank_sh;
        logic [cise_pkg::PC_W-1:0] top_of_return_stack;
        logic push;
        logic [WDT_W-1:0] wdt;
        logic [POST_W-1:0] post;
        logic timeout;
        cise_pkg::cise_dm_req_type dm;
        logic [cise_pkg::DATA_W-1:0] rdata;
    } cise_exec_state_type;

    cise_exec_state_type r_q;
    cise_exec_state_type r_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [cise_pkg::DM_AW-1:0] file_addr(input logic [7:0] f, input logic a,
                                                             input logic [3:0] bank, input logic ext,
                                                             input logic [cise_pkg::DM_AW-1:0] fsr2);
        if (a) begin
            file_addr = {bank, f};
        end else if (ext && f <= cise_pkg::INDEXED_MAX) begin
            file_addr = fsr2 + {4'h0, f};
        end else if (f < cise_pkg::ACCESS_SPLIT) begin
            file_addr = {cise_pkg::ACCESS_LO_BANK, f};
        end else begin
            file_addr = {cise_pkg::ACCESS_HI_BANK, f};
        end
    endfunction

    // the counter still holds the branch word's own address, hence the plus two
    function automatic logic [cise_pkg::PC_W-1:0] branch_dest(input logic [cise_pkg::PC_W-1:0] pc,
                                                               input logic [7:0] n);
        branch_dest = pc + 21'h00_0002 + {{(cise_pkg::PC_W - 9){n[7]}}, n, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic exec;
    logic is_btg;
    logic is_bov;
    logic is_bz;
    logic is_call;
    logic is_clear_file_op;
    logic is_clear_watchdog_op;
    logic is_file;
    logic take;

    always_comb begin
        exec = (r_q.st == cise_pkg::ST_EXEC);
        is_btg = exec && (r_q.ir[15:12] == cise_pkg::OP_BTG_PFX);
        is_bov = exec && (r_q.ir[15:8] == cise_pkg::OP_BOV);
        is_bz = exec && (r_q.ir[15:8] == cise_pkg::OP_BZ);
        is_call = exec && (r_q.ir[15:9] == cise_pkg::OP_CALL_PFX);
        is_clear_file_op = exec && (r_q.ir[15:9] == cise_pkg::OP_CLEAR_FILE_OP_PFX);
        is_clear_watchdog_op = exec && (r_q.ir == cise_pkg::OP_CLEAR_WATCHDOG_OP);
        is_file = is_btg || is_clear_file_op;
        take = (is_bov && r_q.status[cise_pkg::ST_OV]) || (is_bz && r_q.status[cise_pkg::ST_Z]);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        // anything not named below holds, so toggle, branch and call leave the flags alone
        r_d = r_q;
        r_d.q = r_q.q + 2'h1;
        r_d.push = 1'b0;
        r_d.timeout = 1'b0;
        r_d.dm.we = 1'b0;
        r_d.rdata = '0;

        // software writes first, so hardware updates in the same edge win
        if (reg_wr) begin
            case (reg_addr)
                cise_pkg::REG_CTRL: begin
                    r_d.ext_en = reg_wdata[0];
                end
                cise_pkg::REG_STATUS: begin
                    r_d.status = {3'h0, reg_wdata[4:0]};
                end
                cise_pkg::REG_BANK: begin
                    r_d.bank = reg_wdata[3:0];
                end
                cise_pkg::REG_WORK: begin
                    r_d.work = reg_wdata[7:0];
                end
                cise_pkg::REG_FSR2: begin
                    r_d.fsr2 = reg_wdata[cise_pkg::DM_AW-1:0];
                end
                default: begin
                end
            endcase
        end

        if (reg_rd) begin
            case (reg_addr)
                cise_pkg::REG_CTRL: r_d.rdata = {31'h0, r_q.ext_en};
                cise_pkg::REG_STATUS: r_d.rdata = {22'h0, r_q.to_n, r_q.pd_n, r_q.status};
                cise_pkg::REG_BANK: r_d.rdata = {28'h0, r_q.bank};
                cise_pkg::REG_WORK: r_d.rdata = {24'h0, r_q.work};
                cise_pkg::REG_FSR2: r_d.rdata = {20'h0, r_q.fsr2};
                cise_pkg::REG_PC: r_d.rdata = {11'h0, r_q.pc};
                cise_pkg::REG_TOS: r_d.rdata = {11'h0, r_q.top_of_return_stack};
                cise_pkg::REG_SHADOW: r_d.rdata = {12'h0, r_q.bank_sh, r_q.status_sh, r_q.work_sh};
                cise_pkg::REG_WDT: r_d.rdata = 32'(({r_q.post, r_q.wdt}));
                default: r_d.rdata = '0;
            endcase
        end

        // watchdog ticks once per instruction cycle
        // the clear lands in phase 2 and the tick in phase 3, so the two never collide
        if (r_q.q == 2'h3) begin
            r_d.wdt = r_q.wdt + 1'b1;
            if (&r_q.wdt) begin
                r_d.post = r_q.post + 1'b1;
                if (&r_q.post) begin
                    r_d.timeout = 1'b1;
                    r_d.to_n = 1'b0;
                end
            end
        end

        case (r_q.q)
            2'h0: begin
                // decode: the word on the fetch port belongs to this cycle
                r_d.ir = instr_word;
            end
            2'h1: begin
                // read: present the file address
                if (is_file) begin
                    r_d.dm.addr = file_addr(r_q.ir[7:0], r_q.ir[8], r_q.bank, r_q.ext_en, r_q.fsr2);
                end
            end
            2'h2: begin
                // process
                if (is_btg) begin
                    r_d.dm.wdata = dm_rdata ^ (8'h01 << r_q.ir[11:9]);
                    r_d.dm.we = 1'b1;
                end
                if (is_clear_file_op) begin
                    r_d.dm.wdata = 8'h00;
                    r_d.dm.we = 1'b1;
                end
                if (is_call) begin
                    r_d.top_of_return_stack = r_q.pc + 21'h00_0004;
                    r_d.push = 1'b1;
                    r_d.fetch = r_q.pc + 21'h00_0002;
                    if (r_q.ir[8]) begin
                        r_d.work_sh = r_q.work;
                        r_d.status_sh = r_q.status;
                        r_d.bank_sh = r_q.bank;
                    end
                end
                if (is_clear_watchdog_op) begin
                    r_d.wdt = '0;
                    r_d.post = '0;
                    r_d.to_n = 1'b1;
                    r_d.pd_n = 1'b1;
                    r_d.timeout = 1'b0;
                end
            end
            default: begin
                // write phase closes the cycle and picks the next fetch
                r_d.st = cise_pkg::ST_EXEC;
                if (!exec) begin
                    r_d.pc = r_q.pc;
                end else if (take) begin
                    r_d.pc = branch_dest(r_q.pc, r_q.ir[7:0]);
                    r_d.st = cise_pkg::ST_FLUSH;
                end else if (is_call) begin
                    r_d.pc = {instr_word[11:0], r_q.ir[7:0], 1'b0};
                    r_d.st = cise_pkg::ST_FLUSH;
                end else begin
                    r_d.pc = r_q.pc + 21'h00_0002;
                end
                if (is_clear_file_op) begin
                    r_d.status[cise_pkg::ST_Z] = 1'b1;
                end
                r_d.fetch = r_d.pc;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r_q <= '{q: 2'h0, st: cise_pkg::ST_EXEC, ir: cise_pkg::IR_RST, pc: cise_pkg::PC_RST,
                     fetch: cise_pkg::PC_RST, status: cise_pkg::STATUS_RST, to_n: 1'b1, pd_n: 1'b1,
                     bank: 4'h0, work: 8'h00, fsr2: 12'h000, ext_en: 1'b0, work_sh: 8'h00,
                     status_sh: 8'h00, bank_sh: 4'h0, top_of_return_stack: cise_pkg::PC_RST, push: 1'b0,
                     wdt: '0, post: '0, timeout: 1'b0, dm: '0, rdata: '0};
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prog_addr = r_q.fetch;
    assign dm_req = r_q.dm;
    assign stack_push = r_q.push;
    assign stack_tos = r_q.top_of_return_stack;
    assign wdt_timeout = r_q.timeout;
    assign reg_rdata = r_q.rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_btg_flip;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h2 && is_btg) |=> r_q.dm.we && (r_q.dm.wdata == ($past(dm_rdata) ^ (8'h01 << r_q.ir[11:9])));
    endproperty
    a_btg_flip: assert property (p_btg_flip) else $error("toggle wrote wrong byte");

    property p_bank_sel;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h1 && is_file && r_q.ir[8] && !reg_wr)
        |=> r_q.dm.addr == {r_q.bank, r_q.ir[7:0]};
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

    property p_indexed;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h1 && is_file && !r_q.ir[8] && r_q.ext_en && r_q.ir[7:0] <= cise_pkg::INDEXED_MAX && !reg_wr)
        |=> r_q.dm.addr == r_q.fsr2 + {4'h0, r_q.ir[7:0]};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_bov_hold;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && is_bov && !r_q.status[3]) |=> r_q.pc == $past(r_q.pc) + 21'h00_0002 && exec;
    endproperty
    a_bov_hold: assert property (p_bov_hold) else $error("overflow branch taken wrongly");

    property p_bz_hold;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && is_bz && !r_q.status[cise_pkg::ST_Z]) |=> r_q.pc == $past(r_q.pc) + 21'h00_0002 && exec;
    endproperty
    a_bz_hold: assert property (p_bz_hold) else $error("zero branch taken wrongly");

    property p_bz_jump;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && is_bz && r_q.status[2])
        |=> r_q.pc == $past(r_q.pc) + 21'h00_0002 + {{12{r_q.ir[7]}}, r_q.ir[7:0], 1'b0};
    endproperty
    a_bz_jump: assert property (p_bz_jump) else $error("zero branch target wrong");

    property p_taken_idle;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && (take || is_call)) |=> (r_q.st == cise_pkg::ST_FLUSH && !r_q.dm.we)[*4]
        ##1 r_q.st == cise_pkg::ST_EXEC;
    endproperty
    a_taken_idle: assert property (p_taken_idle) else $error("no idle cycle after jump");

    property p_call_push;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h2 && is_call) |=> stack_push && stack_tos == $past(r_q.pc) + 21'h00_0004
        && prog_addr == $past(r_q.pc) + 21'h00_0002;
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_call_dest;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && is_call) |=> r_q.pc == {$past(instr_word[11:0]), r_q.ir[7:0], 1'b0};
    endproperty
    a_call_dest: assert property (p_call_dest) else $error("call target wrong");

    property p_shadow_keep;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h2 && is_call && !r_q.ir[8]) |=> $stable(r_q.work_sh) && $stable(r_q.status_sh)
        && $stable(r_q.bank_sh);
    endproperty
    a_shadow_keep: assert property (p_shadow_keep) else $error("shadows changed");

    property p_clear_file_op;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h2 && is_clear_file_op) |=> r_q.dm.we && r_q.dm.wdata == 8'h00 ##1 r_q.status[2];
    endproperty
    a_clear_file_op: assert property (p_clear_file_op) else $error("clear file wrong");

    property p_clear_watchdog_op;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h2 && is_clear_watchdog_op) |=> r_q.wdt == '0 && r_q.post == '0 && r_q.to_n && r_q.pd_n;
    endproperty
    a_clear_watchdog_op: assert property (p_clear_watchdog_op) else $error("watchdog not cleared");

    property p_flags_kept;
        @(posedge clock) disable iff (!rstn)
        (r_q.q == 2'h3 && (is_btg || is_bov || is_bz || is_call) && !reg_wr) |=> $stable(r_q.status);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags disturbed");

endmodule // cise_exec

// file: cise_mem_model.sv
// program memory and data memory standing behind the instruction-slice executor
// assumes combinational reads and byte writes on the executor's own clock
`timescale 1ns/1ps
module cise_mem_model (
    // clock
    input wire logic clock,
    // program memory
    input wire logic [cise_pkg::PC_W-1:0] prog_addr,
    output logic [15:0] instr_word,
    // data memory
    input wire cise_pkg::cise_dm_req_type dm_req,
    output logic [7:0] dm_rdata
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [15:0] pm [0:1023];
    logic [7:0] dm [0:4095];
    // byte fetch address, bit 0 ignored; upper bits wrap beyond 2 kbyte
    assign instr_word = pm[prog_addr[10:1]];
    assign dm_rdata = dm[dm_req.addr];
    always @(posedge clock) begin
        if (dm_req.we === 1'b1) begin
            dm[dm_req.addr] <= dm_req.wdata;
        end
    end
endmodule // cise_mem_model

// file: cise_exec_tb.sv
// self-checking bench for the instruction-slice executor
// assumes the memory model on fetch and data ports; bench owns the register port
`timescale 1ns/1ps
module cise_exec_tb;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] instr_word;
    logic [cise_pkg::PC_W-1:0] prog_addr;
    logic [7:0] dm_rdata;
    cise_pkg::cise_dm_req_type dm_req;
    logic stack_push;
    logic [cise_pkg::PC_W-1:0] stack_tos;
    logic wdt_timeout;
    logic [cise_pkg::RA_W-1:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 49831;
    int cyc = 0;
    int pushes = 0;
    int timeouts = 0;
    int seen [0:1023];
    logic [20:0] exp_tos;
    logic [31:0] rd_val;
    logic [7:0] work, d1, d2;
    logic [2:0] rb;
    logic [11:0] base;

    always #(cise_pkg::CLK_NS / 2.0) clock = ~clock;

    // small watchdog so a time-out happens inside the preamble
    cise_exec #(.WDT_W(2), .POST_W(1)) i_cise_exec (.clock(clock), .rstn(rstn), .instr_word(instr_word),
        .prog_addr(prog_addr), .dm_rdata(dm_rdata), .dm_req(dm_req), .stack_push(stack_push),
        .stack_tos(stack_tos), .wdt_timeout(wdt_timeout), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    cise_mem_model i_cise_mem_model (.clock(clock), .prog_addr(prog_addr), .instr_word(instr_word),
        .dm_req(dm_req), .dm_rdata(dm_rdata));

    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        cmp_count++;
        if (seen_v !== exp_v) begin
            miscompares++;
            $display("BAD at %0t: seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // first time each fetch word shows up, for cycle spacing
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (seen[prog_addr[10:1]] < 0) begin
            seen[prog_addr[10:1]] <= cyc;
        end
        if (stack_push === 1'b1) begin
            pushes <= pushes + 1;
            check(stack_tos, exp_tos);
        end
        if (wdt_timeout === 1'b1) begin
            timeouts <= timeouts + 1;
        end
    end

    // ----------------------------------------
    // expectations and encodings
    // ----------------------------------------
    function automatic logic [15:0] btg_w(input logic [7:0] f, input logic [2:0] b, input logic a);
        return {cise_pkg::OP_BTG_PFX, b, a, f};
    endfunction
    function automatic logic [15:0] clear_file_op_w(input logic [7:0] f, input logic a);
        return {cise_pkg::OP_CLEAR_FILE_OP_PFX, a, f};
    endfunction
    function automatic logic [20:0] target(input logic [20:0] pc, input logic [7:0] n);
        return pc + 21'h2 + {{12{n[7]}}, n, 1'b0};
    endfunction

    // ----------------------------------------
    // drivers
    // ----------------------------------------
    task automatic put(input int w, input logic [15:0] v);
        i_cise_mem_model.pm[w] = v;
    endtask
    task automatic put_call(input int w, input logic s, input logic [19:0] k);
        put(w, {cise_pkg::OP_CALL_PFX, s, k[7:0]});
        put(w + 1, {cise_pkg::OP_CALL2_PFX, k[19:8]});
    endtask
    task automatic clear_prog;
        for (int i = 0; i < 1024; i++) begin
            put(i, cise_pkg::OP_NOP);
        end
    endtask
    task automatic reset_dut;
        rstn <= 1'b0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 1024; i++) begin
            seen[i] = -1;
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic wait_pc(input logic [20:0] pc, input int bound);
        int n = 0;
        while (prog_addr !== pc && n < bound) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (prog_addr !== pc) begin
            miscompares++;
            report_and_stop();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        clear_prog();
        d1 = 8'($random(seed));
        rb = 3'($random(seed));
        work = 8'($random(seed));
        i_cise_mem_model.dm[12'h010] = 8'h75;
        i_cise_mem_model.dm[12'h322] = d1;
        i_cise_mem_model.dm[12'hF70] = 8'h5A;
        i_cise_mem_model.dm[12'h050] = 8'h3C;
        i_cise_mem_model.dm[12'h051] = 8'h01;
        put(16, btg_w(8'h10, 3'h4, 1'b0));
        put(17, btg_w(8'h22, rb, 1'b1));
        put(18, clear_file_op_w(8'h70, 1'b0));
        put(19, {cise_pkg::OP_BOV, 8'h05});
        put(20, {cise_pkg::OP_BZ, 8'h02});
        put(21, btg_w(8'h50, 3'h0, 1'b0));
        put(22, btg_w(8'h50, 3'h1, 1'b0));
        put_call(23, 1'b1, 20'h0_0030);
        put(25, btg_w(8'h50, 3'h0, 1'b0));
        put(48, cise_pkg::OP_CLEAR_WATCHDOG_OP);
        put(49, {cise_pkg::OP_BZ, 8'h7F});
        put(177, btg_w(8'h51, 3'h7, 1'b0));
        put(178, {cise_pkg::OP_BZ, 8'hFF});
        exp_tos = 21'h2E + 21'h4;
        reset_dut();
        reg_write(cise_pkg::REG_WORK, {24'h0, work});
        reg_write(cise_pkg::REG_BANK, 32'h0000_0003);
        reg_write(cise_pkg::REG_STATUS, 32'h0000_0011);
        reg_write(cise_pkg::REG_CTRL, 32'h0000_0000);
        repeat (30) @(posedge clock);
        reg_read(cise_pkg::REG_STATUS, rd_val);
        check(rd_val, 32'h0000_0111);
        // a 2-bit count behind a 1-bit postscaler wraps every 32 clocks, so one pulse by now
        check(timeouts, 32'h0000_0001);
        wait_pc(21'h62, 300);
        reg_read(cise_pkg::REG_STATUS, rd_val);
        check(rd_val, 32'h0000_0315);
        reg_read(cise_pkg::REG_WDT, rd_val);
        check(rd_val[31:2], 32'h0000_0000);
        wait_pc(target(21'h62, 8'h7F) + 21'h2, 300);
        repeat (6) @(posedge clock);
        reg_read(cise_pkg::REG_PC, rd_val);
        check(rd_val, {11'h0, target(21'h164, 8'hFF)});
        reg_read(cise_pkg::REG_SHADOW, rd_val);
        check(rd_val, {12'h0, 4'h3, 8'h15, work});
        check(i_cise_mem_model.dm[12'h010], 8'h65);
        check(i_cise_mem_model.dm[12'h322], d1 ^ (8'h01 << rb));
        check(i_cise_mem_model.dm[12'hF70], 8'h00);
        check(i_cise_mem_model.dm[12'h050], 8'h3C);
        check(i_cise_mem_model.dm[12'h051], 8'h81);
        check(seen[23] - seen[20], 32'h0000_0004);
        check(seen[48] - seen[23], 32'h0000_0008);
        check(seen[49] - seen[48], 32'h0000_0008);
        check(seen[178] - seen[177], 32'h0000_0008);
        // second run after a reset in mid-loop: indexed mode, taken overflow branch, plain call
        clear_prog();
        d2 = 8'($random(seed));
        base = 12'($random(seed));
        base[11:10] = 2'h1;
        i_cise_mem_model.dm[base + 12'h020] = d2;
        i_cise_mem_model.dm[12'h020] = 8'h33;
        i_cise_mem_model.dm[12'hF60] = 8'hAA;
        i_cise_mem_model.dm[12'hA05] = 8'h3C;
        put(15, {cise_pkg::OP_BZ, 8'h01});
        put(16, btg_w(8'h20, 3'h3, 1'b0));
        put(17, clear_file_op_w(8'h60, 1'b0));
        put(18, {cise_pkg::OP_BOV, 8'h01});
        put(19, btg_w(8'h05, 3'h0, 1'b1));
        put_call(20, 1'b0, 20'h0_0040);
        put(64, {cise_pkg::OP_BZ, 8'hFF});
        exp_tos = 21'h28 + 21'h4;
        reset_dut();
        reg_write(cise_pkg::REG_CTRL, 32'h0000_0001);
        reg_write(cise_pkg::REG_FSR2, {20'h0, base});
        reg_write(cise_pkg::REG_BANK, 32'h0000_000A);
        reg_write(cise_pkg::REG_STATUS, 32'h0000_0008);
        reg_write(cise_pkg::REG_WORK, {24'h0, work});
        wait_pc(21'h80, 300);
        repeat (4) @(posedge clock);
        reg_read(cise_pkg::REG_SHADOW, rd_val);
        check(rd_val, 32'h0000_0000);
        check(i_cise_mem_model.dm[base + 12'h020], d2 ^ 8'h08);
        check(i_cise_mem_model.dm[12'h020], 8'h33);
        check(i_cise_mem_model.dm[12'hF60], 8'h00);
        check(i_cise_mem_model.dm[12'hA05], 8'h3C);
        check(pushes, 32'h0000_0002);
        report_and_stop();
    end
endmodule // cise_exec_tb
